// file: verif/tb.sv
`timescale 1ns/1ns
module tb;
   localparam logic [9:0] HI = tses_pkg::HIGH_FLAGS_ADDR;
   localparam logic [9:0] DN = tses_pkg::DONE_FLAGS_ADDR;
   logic                     clock_in = 1'b0;
   logic                     reset_in = 1'b1;
   tses_pkg::tses_events_t   ev       = '0;
   logic                     gp       = 1'b0;
   logic [12:0]              en       = 13'h0000;
   tses_pkg::tses_read_req_t req;
   logic [15:0]              rdata;
   logic                     rvalid;
   logic                     irq_n;
   int                       errors   = 0;
   int                       n_tests  = 0;
   always #2 clock_in = ~clock_in;
   tses_status tses_status_inst (.clock_in(clock_in), .reset_in(reset_in), .events_in(ev),
      .gp_pin_in(gp), .stage_done_irq_enable_in(en), .read_req_in(req),
      .read_data_out(rdata), .read_valid_out(rvalid), .irq_n_out(irq_n));
   tses_host tses_host_inst (.clock_in(clock_in), .read_data_in(rdata),
      .read_valid_in(rvalid), .read_req_out(req));
   ////////////////////////////////
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd(input logic [9:0] a, input logic [15:0] exp);
      logic [15:0] d;
      tses_host_inst.read(a, d);
      chk($sformatf("reg %h", a), exp, d);
   endtask
   task automatic irq(input logic exp);
      repeat (2) @(posedge clock_in);
      chk("irq_n", {15'h0000, exp}, {15'h0000, irq_n});
   endtask
   task automatic done_pulse(input logic [11:0] s);
      @(posedge clock_in);
      ev.done <= s;
      @(posedge clock_in);
      ev.done <= 12'h000;
   endtask
   task print_verdict;
      if (errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////
   initial begin
      repeat (3) @(posedge clock_in);
      reset_in <= 1'b0;
      rd(HI, 16'h0000);
      rd(DN, 16'h0000);
      en <= 13'h0001;
      done_pulse(12'h801);
      irq(1'b0);
      rd(DN, 16'h0801);
      rd(DN, 16'h0000);
      irq(1'b1);
      done_pulse(12'h002);
      irq(1'b1);
      rd(DN, 16'h0002);
      ev.over_upper <= 12'h800;
      rd(HI, 16'h0800);
      rd(HI, 16'h0800);
      ev.over_upper <= 12'h000;
      rd(HI, 16'h0800);
      rd(HI, 16'h0000);
      en <= 13'h1000;
      gp <= 1'b1;
      irq(1'b0);
      rd(DN, 16'h1000);
      en <= 13'h0000;
      gp <= 1'b0;
      irq(1'b1);
      rd(DN, 16'h1000);
      // Event lands in the very cycle the read is taken
      fork
         rd(DN, 16'h0000);
         done_pulse(12'h400);
      join
      rd(DN, 16'h0400);
      // A read elsewhere must leave pending flags alone
      done_pulse(12'h010);
      rd(10'h00B, 16'h0000);
      rd(DN, 16'h0010);
      // Mid-run reset drops a pending interrupt and every flag
      en <= 13'h0001;
      done_pulse(12'h001);
      irq(1'b0);
      reset_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      reset_in <= 1'b0;
      irq(1'b1);
      rd(DN, 16'h0000);
      rd(HI, 16'h0000);
      print_verdict;
   end
   // Whole run is about 80 cycles
   initial begin
      #4000;
      errors++;
      print_verdict;
   end
endmodule // tb

// file: verif/tses_host.sv
`timescale 1ns/1ns
module tses_host (
   // Register read port
   input  wire logic                clock_in,
   input  wire logic [15:0]         read_data_in,
   input  wire logic                read_valid_in,
   output tses_pkg::tses_read_req_t read_req_out
);
   initial read_req_out = '0;
   ////////////////////////////////
   // Host only reads, so unused upper bits are never written back
   task automatic read(input logic [9:0] addr, output logic [15:0] data);
      int n;
      @(posedge clock_in);
      read_req_out <= '{valid: 1'b1, addr: addr};
      @(posedge clock_in);
      read_req_out <= '0;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (read_valid_in !== 1'b1 && n < 4);
      data = (read_valid_in === 1'b1) ? read_data_in : 16'hXXXX;
   endtask
endmodule // tses_host

// file: verilog/tses_pkg.sv
package tses_pkg;
   localparam int        STAGE_COUNT     = 12;
   localparam int        REG_WIDTH       = 16;
   localparam int        ADDR_WIDTH      = 10;
   // Register indices on the parallel register read port
   localparam logic [9:0] HIGH_FLAGS_ADDR = 10'h009;
   localparam logic [9:0] DONE_FLAGS_ADDR = 10'h00A;
   // Field positions
   localparam int        PIN_CHANGE_BIT  = 12;
   // Reset values
   localparam logic [15:0] FLAGS_RESET   = 16'h0000;
   localparam logic [12:0] ENABLE_RESET  = 13'h0000;

   // Events from the converter, one bit per stage
   typedef struct packed {
      logic [11:0] over_upper;   // Level: result above upper threshold
      logic [11:0] done;         // Pulse: conversion finished
   } tses_events_t;

   // Register read request
   typedef struct packed {
      logic       valid;
      logic [9:0] addr;
   } tses_read_req_t;
endpackage

// file: verilog/tses_status.sv
`timescale 1ns/1ns
// What this block does
// - Upper-threshold flag per stage, register 0x009
// - Conversion-done flag per stage, register 0x00A
// - Bit 12 flags general-purpose pin level change
// - Read clears flags unless condition persists
// - Enabled stage completion asserts active-low interrupt
// - Separate enable gates pin-change interrupt
module tses_status (
   // Clock and reset
   input  wire logic                   clock_in,
   input  wire logic                   reset_in,
   // Converter events
   input  wire tses_pkg::tses_events_t events_in,
   // General-purpose input pin, synchronous to clock_in
   input  wire logic                   gp_pin_in,
   // Interrupt enables: stage done [11:0], pin change [12]
   input  wire logic [12:0]            stage_done_irq_enable_in,
   // Register read port
   input  wire tses_pkg::tses_read_req_t read_req_in,
   output logic [15:0]                 read_data_out,
   output logic                        read_valid_out,
   // Interrupt pin
   output logic                        irq_n_out
);

   ////////////////////////////////////////////////////////////////////////////////
   logic [11:0] stage_over_upper_flag_ff;
   logic [12:0] stage_done_flag_ff;
   logic        pin_last_ff;
   logic        pin_armed_ff;
   logic [15:0] read_data_ff;
   logic        read_valid_ff;
   logic        irq_n_ff;

   logic [11:0] nxt_stage_over_upper_flag;
   logic [12:0] nxt_stage_done_flag;
   logic        nxt_pin_last;
   logic        nxt_pin_armed;
   logic [15:0] nxt_read_data;
   logic        nxt_read_valid;
   logic        nxt_irq_n;

   logic        rd_high;
   logic        rd_done;
   logic        pin_change;
   logic [12:0] done_set;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      rd_high    = read_req_in.valid && (read_req_in.addr == tses_pkg::HIGH_FLAGS_ADDR);
      rd_done    = read_req_in.valid && (read_req_in.addr == tses_pkg::DONE_FLAGS_ADDR);
      // First sample after reset only arms the detector, so no false change
      pin_change = pin_armed_ff && (gp_pin_in != pin_last_ff);
      done_set   = {pin_change, events_in.done};
      nxt_pin_last  = gp_pin_in;
      nxt_pin_armed = 1'b1;

      // Set wins over clear: a live condition keeps its flag through a read
      nxt_stage_over_upper_flag = stage_over_upper_flag_ff | events_in.over_upper;
      if (rd_high) begin
         nxt_stage_over_upper_flag = events_in.over_upper;
      end
      nxt_stage_done_flag = stage_done_flag_ff | done_set;
      if (rd_done) begin
         nxt_stage_done_flag = done_set;
      end

      // Snapshot is the value before the clear; unused bits read as zero
      nxt_read_valid = read_req_in.valid;
      nxt_read_data  = tses_pkg::FLAGS_RESET;
      if (rd_high) begin
         nxt_read_data = {4'h0, stage_over_upper_flag_ff};
      end else if (rd_done) begin
         nxt_read_data = {3'h0, stage_done_flag_ff};
      end

      // Interrupt holds while any enabled done or pin flag stays set
      nxt_irq_n = ~|(nxt_stage_done_flag & stage_done_irq_enable_in);
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         stage_over_upper_flag_ff <= tses_pkg::FLAGS_RESET[11:0];
         stage_done_flag_ff       <= tses_pkg::FLAGS_RESET[12:0];
         pin_last_ff              <= 1'b0;
         pin_armed_ff             <= 1'b0;
         read_data_ff             <= tses_pkg::FLAGS_RESET;
         read_valid_ff            <= 1'b0;
         irq_n_ff                 <= 1'b1;
      end else begin
         stage_over_upper_flag_ff <= nxt_stage_over_upper_flag;
         stage_done_flag_ff       <= nxt_stage_done_flag;
         pin_last_ff              <= nxt_pin_last;
         pin_armed_ff             <= nxt_pin_armed;
         read_data_ff             <= nxt_read_data;
         read_valid_ff            <= nxt_read_valid;
         irq_n_ff                 <= nxt_irq_n;
      end
   end

   assign read_data_out  = read_data_ff;
   assign read_valid_out = read_valid_ff;
   assign irq_n_out      = irq_n_ff;

   ////////////////////////////////////////////////////////////////////////////////
   property p_high_set;
      @(posedge clock_in) disable iff (reset_in)
      events_in.over_upper[0] |=> stage_over_upper_flag_ff[0];
   endproperty
   a_high_set: assert property (p_high_set) else $error("upper flag not set");

   property p_done_set;
      @(posedge clock_in) disable iff (reset_in)
      events_in.done[11] |=> stage_done_flag_ff[11];
   endproperty
   a_done_set: assert property (p_done_set) else $error("done flag not set");

   property p_pin_flag;
      @(posedge clock_in) disable iff (reset_in)
      pin_change |=> stage_done_flag_ff[12];
   endproperty
   a_pin_flag: assert property (p_pin_flag) else $error("pin flag not set");

   property p_read_clear;
      @(posedge clock_in) disable iff (reset_in)
      (rd_done && done_set == 13'h0000) |=> (stage_done_flag_ff == 13'h0000);
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read did not clear");

   property p_upper_zero;
      @(posedge clock_in) disable iff (reset_in)
      read_valid_ff |-> (read_data_out[15:13] == 3'h0);
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("unused bits set");

   sequence s_done_enabled;
      events_in.done[0] && stage_done_irq_enable_in[0];
   endsequence
   property p_irq;
      @(posedge clock_in) disable iff (reset_in)
      s_done_enabled |=> !irq_n_out;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not asserted");

   property p_pin_gate;
      @(posedge clock_in) disable iff (reset_in)
      (stage_done_irq_enable_in == 13'h1000 && !nxt_stage_done_flag[12]) |=> irq_n_out;
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("disabled source drove irq");

   property p_capture;
      @(posedge clock_in) disable iff (reset_in)
      rd_high |=> (read_data_out[11:0] == $past(stage_over_upper_flag_ff)
                   && stage_over_upper_flag_ff == $past(events_in.over_upper));
   endproperty
   a_capture: assert property (p_capture) else $error("capture or clear wrong");

   ////////////////////////////////////////////////////////////////////////////////
   // Requests decoded from the port itself, so a broken address decode is seen
   sequence s_read_high;
      read_req_in.valid && (read_req_in.addr == tses_pkg::HIGH_FLAGS_ADDR);
   endsequence
   sequence s_read_done;
      read_req_in.valid && (read_req_in.addr == tses_pkg::DONE_FLAGS_ADDR);
   endsequence
   sequence s_answer;
      read_valid_out;
   endsequence

   // Every request is answered on the next edge, whatever its address
   property p_read_answer;
      @(posedge clock_in) disable iff (reset_in)
      read_req_in.valid |=> s_answer;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");

   property p_read_single;
      @(posedge clock_in) disable iff (reset_in)
      !read_req_in.valid |=> !read_valid_out;
   endproperty
   a_read_single: assert property (p_read_single) else $error("answer without request");

   property p_high_data;
      @(posedge clock_in) disable iff (reset_in)
      s_read_high |=> s_answer
                      ##0 (read_data_out == {4'h0, $past(stage_over_upper_flag_ff)});
   endproperty
   a_high_data: assert property (p_high_data) else $error("upper readback wrong");

   property p_done_data;
      @(posedge clock_in) disable iff (reset_in)
      s_read_done |=> s_answer
                      ##0 (read_data_out == {3'h0, $past(stage_done_flag_ff)});
   endproperty
   a_done_data: assert property (p_done_data) else $error("done readback wrong");

   // Without a read no flag may drop, only new ones may join
   property p_high_keep;
      @(posedge clock_in) disable iff (reset_in)
      !rd_high |=> ((stage_over_upper_flag_ff & $past(stage_over_upper_flag_ff))
                    == $past(stage_over_upper_flag_ff));
   endproperty
   a_high_keep: assert property (p_high_keep) else $error("upper flag lost");

   property p_done_keep;
      @(posedge clock_in) disable iff (reset_in)
      !rd_done |=> ((stage_done_flag_ff & $past(stage_done_flag_ff))
                    == $past(stage_done_flag_ff));
   endproperty
   a_done_keep: assert property (p_done_keep) else $error("done flag lost");

   property p_high_clear;
      @(posedge clock_in) disable iff (reset_in)
      (rd_high && (events_in.over_upper == 12'h000))
         |=> (stage_over_upper_flag_ff == 12'h000);
   endproperty
   a_high_clear: assert property (p_high_clear) else $error("upper read did not clear");

   // A limit still exceeded at the read must survive it
   property p_high_sticky;
      @(posedge clock_in) disable iff (reset_in)
      (rd_high && events_in.over_upper[11]) |=> stage_over_upper_flag_ff[11];
   endproperty
   a_high_sticky: assert property (p_high_sticky) else $error("live limit flag cleared");

   // Checked against the pin's own history, not the detector's register
   property p_pin_edge;
      @(posedge clock_in) disable iff (reset_in)
      (pin_armed_ff && (gp_pin_in != $past(gp_pin_in)))
         |=> stage_done_flag_ff[tses_pkg::PIN_CHANGE_BIT];
   endproperty
   a_pin_edge: assert property (p_pin_edge) else $error("pin edge not flagged");

   property p_pin_irq;
      @(posedge clock_in) disable iff (reset_in)
      (pin_change && stage_done_irq_enable_in[tses_pkg::PIN_CHANGE_BIT]) |=> !irq_n_out;
   endproperty
   a_pin_irq: assert property (p_pin_irq) else $error("enabled pin change no irq");

   property p_irq_masked;
      @(posedge clock_in) disable iff (reset_in)
      (stage_done_irq_enable_in == 13'h0000) |=> irq_n_out;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("masked source drove irq");

   // Interrupt is a level: it stays until a done read or an enable change
   property p_irq_hold;
      @(posedge clock_in) disable iff (reset_in)
      (!irq_n_out && !rd_done && $stable(stage_done_irq_enable_in)) |=> !irq_n_out;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped early");

endmodule // tses_status
